// file: rtl/wait_pulse_timer.v
// Purpose: wait one-shot pulse timer with AHB-Lite register slave
// Assumes: single clock hclk, companion underflow is an hclk pulse
// Notes: zero-wait slave, hrdata sampled at the address phase
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "wait_pulse_timer_regs.vh"

module wait_pulse_timer #(
  parameter WIDTH = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire companion_underflow,
  input wire external_trigger_pin,
  output reg pulse_output_pin,
  output reg timer_irq
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ARMED = 4'b0010;
  localparam [3:0] ST_WAIT = 4'b0100;
  localparam [3:0] ST_PULSE = 4'b1000;

  reg [3:0] state;
  reg count_start_bit;
  reg count_active;
  reg output_level_select;
  reg pin_trigger_enable;
  reg edge_rising;
  reg edge_both;
  reg [1:0] source_select;
  reg [WIDTH-1:0] pre_reload;
  reg [WIDTH-1:0] sec_reload;
  reg [WIDTH-1:0] pri_reload;
  reg [WIDTH-1:0] pre_cnt;
  reg [WIDTH-1:0] pri_cnt;
  reg [2:0] div_cnt;
  reg pin_s1;
  reg pin_s2;
  reg pin_s3;
  reg pin_level;
  reg pin_prev;
  reg dp_write;
  reg [7:0] dp_addr;

  wire oneshot_active_flag;
  assign oneshot_active_flag = state[2] | state[3];

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // no wait states and no error answer; unmapped words read zero
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire addr_phase;
  assign addr_phase = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_write <= addr_phase & hwrite;
      dp_addr <= haddr;
    end
  end

  function wr_hit;
    input [7:0] ofs;
    begin
      wr_hit = dp_write && (dp_addr[7:2] == ofs[7:2]);
    end
  endfunction

  wire wr_ctrl;
  wire wr_oneshot;
  wire wr_io;
  wire wr_src;
  wire wr_pre;
  wire wr_sec;
  wire wr_pri;
  assign wr_ctrl = wr_hit(`OFS_TIMER_CONTROL);
  assign wr_oneshot = wr_hit(`OFS_ONESHOT_CONTROL);
  assign wr_io = wr_hit(`OFS_IO_CONTROL);
  assign wr_src = wr_hit(`OFS_SOURCE_SELECT);
  assign wr_pre = wr_hit(`OFS_PRESCALER);
  assign wr_sec = wr_hit(`OFS_SECONDARY);
  assign wr_pri = wr_hit(`OFS_PRIMARY);

  wire sw_start;
  wire sw_stop;
  wire sw_force;
  wire sw_run_clear;
  assign sw_start = wr_oneshot & hwdata[`BIT_ONESHOT_START];
  assign sw_stop = wr_oneshot & hwdata[`BIT_ONESHOT_STOP];
  assign sw_force = wr_ctrl & hwdata[`BIT_FORCED_STOP];
  assign sw_run_clear = wr_ctrl & ~hwdata[`BIT_COUNT_START];

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (haddr[7:2])
      `OFS_TIMER_CONTROL >> 2: begin
        next_rdata[`BIT_COUNT_START] = count_start_bit;
        next_rdata[`BIT_COUNT_ACTIVE] = count_active;
      end
      `OFS_ONESHOT_CONTROL >> 2: begin
        next_rdata[`BIT_ONESHOT_ACTIVE] = oneshot_active_flag;
      end
      `OFS_IO_CONTROL >> 2: begin
        next_rdata[`BIT_OUTPUT_LEVEL] = output_level_select;
        next_rdata[`BIT_PIN_TRIG_EN] = pin_trigger_enable;
        next_rdata[`BIT_EDGE_RISING] = edge_rising;
        next_rdata[`BIT_EDGE_BOTH] = edge_both;
        next_rdata[`BIT_PIN_LEVEL] = pin_level;
      end
      `OFS_SOURCE_SELECT >> 2: begin
        next_rdata[`SRC_MSB:`SRC_LSB] = source_select;
      end
      `OFS_PRESCALER >> 2: begin
        next_rdata[WIDTH-1:0] = pre_cnt;
      end
      `OFS_SECONDARY >> 2: begin
        next_rdata[WIDTH-1:0] = sec_reload;
      end
      `OFS_PRIMARY >> 2: begin
        next_rdata[WIDTH-1:0] = pri_cnt;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_level_select <= 1'b0;
      pin_trigger_enable <= 1'b0;
      edge_rising <= 1'b0;
      edge_both <= 1'b0;
      source_select <= `RST_SOURCE;
      pre_reload <= `RST_PERIOD;
      sec_reload <= `RST_PERIOD;
      pri_reload <= `RST_PERIOD;
    end else begin
      if (wr_io) begin
        output_level_select <= hwdata[`BIT_OUTPUT_LEVEL];
        pin_trigger_enable <= hwdata[`BIT_PIN_TRIG_EN];
        edge_rising <= hwdata[`BIT_EDGE_RISING];
        edge_both <= hwdata[`BIT_EDGE_BOTH];
      end
      if (wr_src) begin
        source_select <= hwdata[`SRC_MSB:`SRC_LSB];
      end
      // reload side always takes the write, running or not
      if (wr_pre) begin
        pre_reload <= hwdata[WIDTH-1:0];
      end
      if (wr_sec) begin
        sec_reload <= hwdata[WIDTH-1:0];
      end
      if (wr_pri) begin
        pri_reload <= hwdata[WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // count source
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  reg tick;
  always @* begin
    case (source_select)
      `SRC_DIV1: tick = 1'b1;
      `SRC_DIV2: tick = div_cnt[0];
      `SRC_DIV8: tick = (div_cnt == `DIV8_LAST);
      `SRC_COMPANION: tick = companion_underflow;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // external trigger pin
  // ----------------------------------------------------------------
  // level follows only once the last two stages agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      pin_level <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_s1 <= external_trigger_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
      pin_prev <= pin_level;
    end
  end

  wire pin_rise;
  wire pin_fall;
  wire pin_edge;
  assign pin_rise = pin_level & ~pin_prev;
  assign pin_fall = ~pin_level & pin_prev;
  assign pin_edge = edge_both ? (pin_rise | pin_fall) :
                    (edge_rising ? pin_rise : pin_fall);

  wire trigger;
  assign trigger = sw_start | (pin_trigger_enable & pin_edge);

  // ----------------------------------------------------------------
  // sequencer and counters
  // ----------------------------------------------------------------
  wire pre_zero;
  wire underflow;
  wire counting;
  wire abort;
  assign pre_zero = (pre_cnt == {WIDTH{1'b0}});
  assign counting = state[2] | state[3];
  assign underflow = counting & tick & pre_zero & (pri_cnt == {WIDTH{1'b0}});
  // any stop request reloads and parks the sequencer in the same edge
  assign abort = sw_force | sw_run_clear | sw_stop;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      count_start_bit <= 1'b0;
      count_active <= 1'b0;
      pre_cnt <= `RST_PERIOD;
      pri_cnt <= `RST_PERIOD;
      pulse_output_pin <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= 1'b0;
      if (wr_ctrl) begin
        count_start_bit <= hwdata[`BIT_COUNT_START] & ~hwdata[`BIT_FORCED_STOP];
      end
      if (sw_force || sw_run_clear) begin
        count_active <= 1'b0;
      end else if (count_start_bit && tick) begin
        count_active <= 1'b1;
      end
      if (abort) begin
        pre_cnt <= pre_reload;
        pri_cnt <= pri_reload;
        state <= ST_IDLE;
        pulse_output_pin <= output_level_select;
      end else begin
        if (wr_pre && !count_active) begin
          pre_cnt <= hwdata[WIDTH-1:0];
        end
        if (wr_pri && !count_active) begin
          pri_cnt <= hwdata[WIDTH-1:0];
        end
        case (state)
          ST_IDLE: begin
            pulse_output_pin <= output_level_select;
            if (trigger && count_active) begin
              state <= ST_ARMED;
            end
          end
          ST_ARMED: begin
            if (!count_active) begin
              state <= ST_IDLE;
            end else if (tick) begin
              state <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            pulse_output_pin <= output_level_select;
            if (tick) begin
              if (!pre_zero) begin
                pre_cnt <= pre_cnt - {{(WIDTH-1){1'b0}}, 1'b1};
              end else begin
                pre_cnt <= pre_reload;
                if (underflow) begin
                  pri_cnt <= sec_reload;
                  state <= ST_PULSE;
                  pulse_output_pin <= ~output_level_select;
                end else begin
                  pri_cnt <= pri_cnt - {{(WIDTH-1){1'b0}}, 1'b1};
                end
              end
            end
          end
          ST_PULSE: begin
            pulse_output_pin <= ~output_level_select;
            if (tick) begin
              if (!pre_zero) begin
                pre_cnt <= pre_cnt - {{(WIDTH-1){1'b0}}, 1'b1};
              end else begin
                pre_cnt <= pre_reload;
                if (underflow) begin
                  pri_cnt <= pri_reload;
                  state <= ST_IDLE;
                  pulse_output_pin <= output_level_select;
                  timer_irq <= 1'b1;
                end else begin
                  pri_cnt <= pri_cnt - {{(WIDTH-1){1'b0}}, 1'b1};
                end
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
  // a trigger while a sequence runs finds no IDLE state and is dropped

endmodule // wait_pulse_timer

// file: rtl/wait_pulse_timer_regs.vh
// Purpose: register map and constants of the wait one-shot pulse timer
// Assumes: byte addresses on a 32-bit AHB-Lite bus, one register per word
// Notes: definitions only
`ifndef WAIT_PULSE_TIMER_REGS_VH
`define WAIT_PULSE_TIMER_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_TIMER_CONTROL 8'h00
`define OFS_ONESHOT_CONTROL 8'h04
`define OFS_IO_CONTROL 8'h08
`define OFS_SOURCE_SELECT 8'h0c
`define OFS_PRESCALER 8'h10
`define OFS_SECONDARY 8'h14
`define OFS_PRIMARY 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_COUNT_START 0
`define BIT_COUNT_ACTIVE 1
`define BIT_FORCED_STOP 2
`define BIT_ONESHOT_START 0
`define BIT_ONESHOT_STOP 1
`define BIT_ONESHOT_ACTIVE 2
`define BIT_OUTPUT_LEVEL 0
`define BIT_PIN_TRIG_EN 2
`define BIT_EDGE_RISING 3
`define BIT_EDGE_BOTH 4
`define BIT_PIN_LEVEL 5
`define SRC_LSB 0
`define SRC_MSB 1

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define SRC_DIV1 2'h0
`define SRC_DIV2 2'h1
`define SRC_DIV8 2'h2
`define SRC_COMPANION 2'h3
`define DIV8_LAST 3'h7
`define RST_PERIOD 8'hff
`define RST_IO 5'h00
`define RST_SOURCE 2'h0
`define HTRANS_NONSEQ_BIT 1

`endif

// file: testbench/wait_pulse_timer_checker.sv
// Purpose: port-level checks of the wait one-shot pulse timer
// Assumes: one clock, reset active low, zero-wait slave
// Notes: output level is tracked by snooping io control writes
`timescale 1ns/100ps
`include "wait_pulse_timer_regs.vh"
module wait_pulse_timer_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire companion_underflow,
  input wire external_trigger_pin,
  input wire pulse_output_pin,
  input wire timer_irq
);
  reg dp_wr;
  reg [7:0] dp_addr;
  reg lvl;
  wire take = hsel && htrans[1] && hready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      lvl <= 1'b0;
    end else begin
      dp_wr <= take && hwrite;
      if (take) dp_addr <= haddr;
      if (dp_wr && dp_addr == `OFS_IO_CONTROL) lvl <= hwdata[0];
    end
  end
  // ----
  // checks
  // ----
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_stop_os;
    dp_wr && dp_addr == `OFS_ONESHOT_CONTROL && hwdata[1];
  endsequence
  sequence s_stop_ctl;
    dp_wr && dp_addr == `OFS_TIMER_CONTROL && (!hwdata[0] || hwdata[2]);
  endsequence
  sequence s_pulse_end;
    $past(pulse_output_pin) != lvl && pulse_output_pin == lvl;
  endsequence
  property p_ready; hreadyout && !hresp; endproperty
  property p_rd_unmapped; take && !hwrite && haddr >= 8'h1c |=> hrdata == 32'h0; endproperty
  property p_rd_upper; take && !hwrite |=> hrdata[31:8] == 24'h0; endproperty
  property p_rd_hold; !(take && !hwrite) |=> $stable(hrdata); endproperty
  property p_irq_one; timer_irq |=> !timer_irq [*3]; endproperty
  property p_irq_end; timer_irq |-> s_pulse_end; endproperty
  property p_stop_os; s_stop_os |=> pulse_output_pin == lvl && !timer_irq; endproperty
  property p_stop_ctl; s_stop_ctl |=> pulse_output_pin == lvl && !timer_irq; endproperty
  a_ready: assert property (p_ready) else $error("slave not ready or not okay");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_rd_upper: assert property (p_rd_upper) else $error("read upper bits not zero");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_irq_one: assert property (p_irq_one) else $error("irq too long");
  a_irq_end: assert property (p_irq_end) else $error("irq not at pulse end");
  a_stop_os: assert property (p_stop_os) else $error("one-shot stop ignored");
  a_stop_ctl: assert property (p_stop_ctl) else $error("count stop ignored");
endmodule // wait_pulse_timer_checker

bind wait_pulse_timer wait_pulse_timer_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .companion_underflow(companion_underflow), .external_trigger_pin(external_trigger_pin),
  .pulse_output_pin(pulse_output_pin), .timer_irq(timer_irq));

// file: testbench/pulse_receiver.sv
// Purpose: circuit on the pulse pin, measures each active run
// Assumes: active level given by the bench
// Notes: a level change may add one short run, so use count deltas
`timescale 1ns/100ps
module pulse_receiver (
  input wire hclk,
  input wire pin,
  input wire active_level,
  output reg [15:0] width,
  output reg [7:0] count
);
  reg [15:0] run;
  initial begin
    run = 16'h0;
    width = 16'h0;
    count = 8'h00;
  end
  always @(posedge hclk) begin
    if (pin === active_level) run <= run + 16'h1;
    else if (run != 16'h0) begin
      width <= run;
      count <= count + 8'h01;
      run <= 16'h0;
    end
  end
endmodule // pulse_receiver

// file: testbench/wait_oneshot_pulse_timer_tb.sv
// Purpose: self-checking bench of the wait one-shot pulse timer
// Assumes: companion underflow every 4 clocks
// Notes: settings keep prescaler and primary off zero together
`timescale 1ns/100ps
`include "wait_pulse_timer_regs.vh"
module wait_oneshot_pulse_timer_tb;
  reg hclk = 0;
  reg hresetn = 0;
  reg hsel = 0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 0;
  reg [31:0] hwdata = 32'h0;
  reg companion_underflow = 0;
  reg external_trigger_pin = 0;
  reg active_level = 1;
  reg [1:0] cdiv = 2'h0;
  wire hready;
  wire hresp;
  wire [31:0] hrdata;
  wire pulse_output_pin;
  wire timer_irq;
  wire [15:0] rx_width;
  wire [7:0] rx_count;
  integer n_errors = 0;
  integer checked = 0;
  integer n_irq = 0;
  integer tk [0:3] = '{1, 2, 8, 4};
  integer s;
  integer c0;
  reg [31:0] q;
  wait_pulse_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .companion_underflow(companion_underflow), .external_trigger_pin(external_trigger_pin),
    .pulse_output_pin(pulse_output_pin), .timer_irq(timer_irq));
  pulse_receiver rx (.hclk(hclk), .pin(pulse_output_pin), .active_level(active_level),
    .width(rx_width), .count(rx_count));
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cdiv <= cdiv + 2'h1;
    companion_underflow <= (cdiv == 2'h3);
    if (timer_irq === 1'b1) n_irq <= n_irq + 1;
  end
  // ----
  // helpers
  // ----
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input wr, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdm(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
    end
  endtask
  task arm;
    integer i;
    begin
      wr(`OFS_TIMER_CONTROL, 32'h1);
      q = 32'h0;
      for (i = 0; i < 50 && q[`BIT_COUNT_ACTIVE] !== 1'b1; i = i + 1)
        bus(1'b0, `OFS_TIMER_CONTROL, 32'h0);
      chk(q, 32'h3);
    end
  endtask
  // one trigger, by start bit or pin edge; w is the pulse width in clocks
  task shot(input pin, input integer lo, input integer hi, input [31:0] w);
    integer t;
    integer i0;
    begin
      c0 = rx_count;
      i0 = n_irq;
      if (pin) external_trigger_pin <= 1'b1;
      else wr(`OFS_ONESHOT_CONTROL, 32'h1);
      for (t = 0; t < 900 && pulse_output_pin !== active_level; t = t + 1) @(posedge hclk);
      chk(32'(t >= lo && t <= hi), 32'h1);
      for (t = 0; t < 900 && rx_count == c0; t = t + 1) @(posedge hclk);
      external_trigger_pin <= 1'b0;
      chk({16'h0, rx_width}, w);
      chk(n_irq - i0, 32'h1);
      rdm(`OFS_ONESHOT_CONTROL, 32'h4, 32'h0);
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    begin
      rdm(`OFS_PRIMARY, 32'hffffffff, 32'hff);
      rdm(8'h1c, 32'hffffffff, 32'h0);
      rdm(`OFS_TIMER_CONTROL, 32'hffffffff, 32'h0);
    end
  endtask
  task t_sources;
    for (s = 0; s < 4; s = s + 1) begin
      wr(`OFS_SOURCE_SELECT, s);
      rdm(`OFS_SOURCE_SELECT, 32'h3, s);
      wr(`OFS_PRESCALER, 32'h1);
      wr(`OFS_SECONDARY, 32'h3);
      wr(`OFS_PRIMARY, 32'h2);
      rdm(`OFS_PRESCALER, 32'hffffffff, 32'h1);
      arm;
      shot(1'b0, 6 * tk[s], 9 * tk[s] + 6, 8 * tk[s]);
      rdm(`OFS_PRIMARY, 32'hffffffff, 32'h2);
      wr(`OFS_TIMER_CONTROL, 32'h0);
    end
  endtask
  task t_retrig;
    begin
      wr(`OFS_SOURCE_SELECT, 32'h0);
      arm;
      // running: the write must reach the reload side only
      wr(`OFS_PRIMARY, 32'h7);
      rdm(`OFS_PRIMARY, 32'hffffffff, 32'h2);
      wr(`OFS_PRIMARY, 32'h2);
      c0 = rx_count;
      wr(`OFS_ONESHOT_CONTROL, 32'h1);
      // secondary reload is taken at the primary underflow of this run
      wr(`OFS_SECONDARY, 32'h5);
      wr(`OFS_ONESHOT_CONTROL, 32'h1);
      repeat (60) @(posedge hclk);
      chk(rx_count - c0, 32'h1);
      chk({16'h0, rx_width}, 32'd12);
      shot(1'b0, 6, 15, 32'd12);
    end
  endtask
  task t_pin;
    begin
      wr(`OFS_IO_CONTROL, 32'h01);
      active_level <= 1'b0;
      repeat (4) @(posedge hclk);
      c0 = rx_count;
      external_trigger_pin <= 1'b1;
      repeat (30) @(posedge hclk);
      chk(rx_count - c0, 32'h0);
      external_trigger_pin <= 1'b0;
      repeat (8) @(posedge hclk);
      wr(`OFS_IO_CONTROL, 32'h0d);
      shot(1'b1, 6, 15, 32'd12);
      chk({31'h0, pulse_output_pin}, 32'h1);
      // let the pin fall settle before both edges are armed
      repeat (8) @(posedge hclk);
      wr(`OFS_IO_CONTROL, 32'h15);
      rdm(`OFS_IO_CONTROL, 32'h3f, 32'h15);
      c0 = rx_count;
      external_trigger_pin <= 1'b1;
      repeat (40) @(posedge hclk);
      external_trigger_pin <= 1'b0;
      repeat (40) @(posedge hclk);
      chk(rx_count - c0, 32'h2);
      chk({16'h0, rx_width}, 32'd12);
      wr(`OFS_IO_CONTROL, 32'h00);
      active_level <= 1'b1;
      wr(`OFS_TIMER_CONTROL, 32'h0);
    end
  endtask
  task t_stops;
    begin
      wr(`OFS_PRIMARY, 32'd20);
      for (s = 0; s < 3; s = s + 1) begin
        arm;
        c0 = rx_count + n_irq;
        wr(`OFS_ONESHOT_CONTROL, 32'h1);
        repeat (4) @(posedge hclk);
        rdm(`OFS_ONESHOT_CONTROL, 32'h4, 32'h4);
        if (s == 0) wr(`OFS_ONESHOT_CONTROL, 32'h2);
        else wr(`OFS_TIMER_CONTROL, (s == 1) ? 32'h0 : 32'h4);
        repeat (60) @(posedge hclk);
        chk(rx_count + n_irq - c0, 32'h0);
        rdm(`OFS_PRIMARY, 32'hffffffff, 32'd20);
        rdm(`OFS_TIMER_CONTROL, 32'h2, (s == 0) ? 32'h2 : 32'h0);
        wr(`OFS_TIMER_CONTROL, 32'h0);
      end
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_sources;
    t_retrig;
    t_pin;
    t_stops;
    finish_test;
  end
  // whole run needs about 900 clocks
  initial begin
    #200000;
    n_errors = n_errors + 1;
    finish_test;
  end
endmodule // wait_oneshot_pulse_timer_tb
